// *** hdl/line_dir_params.svh ***
/*
 Timing counts and default figures for the line-direction controller.
 Assumes nothing beyond being included by its bare name.
*/
`ifndef LINE_DIR_PARAMS_SVH
`define LINE_DIR_PARAMS_SVH

// Bit times in one full frame: start, eight data, parity, two stop.
`define FRAME_BITS          12
// Baud clock ticks per bit (the serial reference runs at 16 times the bit rate).
`define TICKS_PER_BIT       16
// Quadrupling factor of the high baud range.
`define RANGE_HIGH_FACTOR   4
// Host I/O address space decoded by the base compare.
`define IO_ADDR_BITS        10
`define IO_ADDR_LOW         10'h000
`define IO_ADDR_HIGH        10'h3ff
// Default base and size of the register block.
`define BASE_DEFAULT        10'h3e8
`define BLOCK_ADDR_BITS     3
// Baud range limits in baud.
`define RANGE_LOW_MIN_BAUD  50
`define RANGE_LOW_MAX_BAUD  115200
`define RANGE_HIGH_MAX_BAUD 460800

`endif

// *** hdl/line_dir_pkg.sv ***
/*
 Types shared by the line-direction controller.
 Assumes the parameter header is compiled alongside.
*/
package line_dir_pkg;
	typedef enum logic [1:0] {
		ST_RECEIVE  = 2'b00,
		ST_TRANSMIT = 2'b01,
		ST_HOLD     = 2'b10
	} dir_state_e;
endpackage

// *** hdl/line_dir_ctrl.sv ***
/*
 Automatic driver and receiver direction control for a shared differential
 serial line, plus the host I/O base decode of the serial block.
 Assumes the UART transmit path gives a same-clock busy level and a
 16x baud tick, and that jumper and address switch levels are static pins.
*/
`timescale 1ns/1ps
`include "line_dir_params.svh"

// Functional notes
// - Idle: receiver on, driver off.
// - Transmit pending: receiver off, driver on first.
// - Hold driver one character after last.
// - Hold length follows programmed baud rate.
// - Half duplex never drives and receives together.
// - Full duplex: both directions, no switching.
// - Jumper picks low or quadrupled high range.
// - Base address on any 8-address boundary in 000 to 3FF.
// - Jumper chooses half or full duplex.
module line_dir_ctrl
	import line_dir_pkg::*;
#(
	parameter int HOLD_TICKS = `FRAME_BITS * `TICKS_PER_BIT
) (
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	input  wire logic                      tx_busy_i,
	input  wire logic                      baud_tick_i,
	input  wire logic                      half_duplex_sel_i,
	input  wire logic                      baud_range_high_i,
	input  wire logic [`IO_ADDR_BITS-1:0]  base_addr_i,
	input  wire logic [`IO_ADDR_BITS-1:0]  io_addr_i,
	output logic                           ref_clk_mult_o,
	output logic                           driver_en_o,
	output logic                           receiver_en_o,
	output logic                           block_sel_o,
	output logic                           tx_allow_o
);
	localparam int CW = $clog2(HOLD_TICKS + 1);

	// Jumpers and switches come from pins, so each passes two flops.
	logic [1:0]               duplex_sync_reg;
	logic [1:0]               range_sync_reg;
	logic [`IO_ADDR_BITS-1:0] base_sync1_reg;
	logic [`IO_ADDR_BITS-1:0] base_sync2_reg;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			duplex_sync_reg <= 2'h3;
			range_sync_reg  <= 2'h0;
			base_sync1_reg  <= `BASE_DEFAULT;
			base_sync2_reg  <= `BASE_DEFAULT;
		end else begin
			duplex_sync_reg <= {duplex_sync_reg[0], half_duplex_sel_i};
			range_sync_reg  <= {range_sync_reg[0], baud_range_high_i};
			base_sync1_reg  <= base_addr_i;
			base_sync2_reg  <= base_sync1_reg;
		end
	end

	wire half_mode = duplex_sync_reg[1];

	function automatic logic in_block(input logic [`IO_ADDR_BITS-1:0] a,
			input logic [`IO_ADDR_BITS-1:0] b);
		in_block = (a[`IO_ADDR_BITS-1:`BLOCK_ADDR_BITS] == b[`IO_ADDR_BITS-1:`BLOCK_ADDR_BITS]);
	endfunction

	dir_state_e      state_reg;
	dir_state_e      state_next;
	logic [CW-1:0]   count_reg;
	logic [CW-1:0]   count_next;
	logic            drv_reg;
	logic            drv_next;
	logic            rcv_reg;
	logic            rcv_next;
	logic            sel_reg;
	logic            sel_next;
	logic            mult_reg;
	logic            mult_next;

	always_comb begin
		state_next = state_reg;
		count_next = count_reg;
		// Only bits 9 to 3 are compared, so the block sits on any 8-address boundary from 000 to 3FF.
		sel_next   = in_block(io_addr_i, base_sync2_reg);
		mult_next  = range_sync_reg[1];
		if (!half_mode) begin
			// Separate pairs: no direction switching is needed.
			state_next = ST_RECEIVE;
			count_next = '0;
			drv_next   = 1'b1;
			rcv_next   = 1'b1;
		end else begin
			unique case (state_reg)
				ST_RECEIVE: begin
					if (tx_busy_i) begin
						state_next = ST_TRANSMIT;
					end
				end
				ST_TRANSMIT: begin
					if (!tx_busy_i) begin
						state_next = ST_HOLD;
						count_next = CW'(HOLD_TICKS);
					end
				end
				ST_HOLD: begin
					if (tx_busy_i) begin
						state_next = ST_TRANSMIT;
					end else if (baud_tick_i) begin
						// The tick already scales with the divisor, so the hold tracks baud.
						if (count_next == CW'(1)) begin
							state_next = ST_RECEIVE;
							count_next = '0;
						end else begin
							count_next = count_reg - CW'(1);
						end
					end
				end
				default: begin
					state_next = ST_RECEIVE;
					count_next = '0;
				end
			endcase
			// Driver and receiver are exclusive in half duplex.
			drv_next = (state_next != ST_RECEIVE);
			rcv_next = (state_next == ST_RECEIVE);
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= ST_RECEIVE;
			count_reg <= '0;
			drv_reg   <= 1'b0;
			rcv_reg   <= 1'b1;
			sel_reg   <= 1'b0;
			mult_reg  <= 1'b0;
		end else begin
			state_reg <= state_next;
			count_reg <= count_next;
			drv_reg   <= drv_next;
			rcv_reg   <= rcv_next;
			sel_reg   <= sel_next;
			mult_reg  <= mult_next;
		end
	end

	assign driver_en_o    = drv_reg;
	assign receiver_en_o  = rcv_reg;
	assign block_sel_o    = sel_reg;
	assign ref_clk_mult_o = mult_reg;
	// Shifting is held off until the driver is already on the line.
	assign tx_allow_o     = drv_reg;
endmodule

// *** bench/line_dir_asserts.sv ***
/* Port checker for the line-direction controller.
 Assumes it is bound onto the controller and the jumpers change rarely. */
`timescale 1ns/1ps
module line_dir_asserts #(parameter int HOLD_TICKS = 4) (
	input wire logic       clk_i,
	input wire logic       rst_i,
	input wire logic       tx_busy_i,
	input wire logic       baud_tick_i,
	input wire logic       half_duplex_sel_i,
	input wire logic       baud_range_high_i,
	input wire logic [9:0] base_addr_i,
	input wire logic [9:0] io_addr_i,
	input wire logic       ref_clk_mult_o,
	input wire logic       driver_en_o,
	input wire logic       receiver_en_o,
	input wire logic       block_sel_o,
	input wire logic       tx_allow_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	int ticks;
	// Six cycles cover the jumper synchroniser, so mode changes never fire these.
	sequence half_steady;
		half_duplex_sel_i[*6];
	endsequence
	always_ff @(posedge clk_i or posedge rst_i)
		if (rst_i) ticks <= 0;
		else if (tx_busy_i) ticks <= 0;
		else if (baud_tick_i && driver_en_o) ticks <= ticks + 1;
	a_allow_drv: assert property (tx_allow_o == driver_en_o)
		else $error("allow differs");
	a_idle_recv: assert property (!tx_busy_i && !driver_en_o |-> receiver_en_o)
		else $error("idle receiver off");
	a_start_drv: assert property (half_steady ##0 (receiver_en_o && tx_busy_i)
		|=> driver_en_o && !receiver_en_o) else $error("no turn round");
	a_no_both: assert property (half_steady |-> !(driver_en_o && receiver_en_o))
		else $error("drive and receive");
	a_full_both: assert property ((!half_duplex_sel_i)[*6] |-> driver_en_o && receiver_en_o)
		else $error("full duplex switched");
	a_hold_len: assert property (half_steady ##0 $fell(driver_en_o)
		|-> ticks == HOLD_TICKS || ticks == HOLD_TICKS + 1) else $error("hold length");
	a_sel_dec: assert property ($stable(base_addr_i)[*4] |=>
		block_sel_o == ($past(io_addr_i[9:3]) == $past(base_addr_i[9:3]))) else $error("decode");
	a_mult_rng: assert property (baud_range_high_i != $past(baud_range_high_i)
		|-> ##3 ref_clk_mult_o == $past(baud_range_high_i, 3)) else $error("range");
endmodule
bind line_dir_ctrl line_dir_asserts #(.HOLD_TICKS(HOLD_TICKS)) u_chk (.*);

// *** bench/uart_tx_model.sv ***
/* UART transmit side: a 16x tick every third cycle and a busy level.
 Assumes the controller grants shifting through its allow output. */
`timescale 1ns/1ps
module uart_tx_model (
	input wire logic clk_i,
	input wire logic tx_allow_i,
	output logic     tx_busy_o,
	output logic     baud_tick_o
);
	int div = 0;
	int left = 0;
	initial begin
		tx_busy_o = 0;
		baud_tick_o = 0;
	end
	task send(input int n);
		left = n * 4;
	endtask
	// Bits shift only while granted, so nothing leaves before the driver is on.
	always @(posedge clk_i) begin
		div = (div + 1) % 3;
		if (baud_tick_o && tx_allow_i && left > 0) left--;
		tx_busy_o <= #1 left > 0;
		baud_tick_o <= #1 div == 0;
	end
endmodule

// *** bench/tb_top.sv ***
/* Top bench for the line-direction controller with a UART model.
 Assumes the hold is shortened to four ticks. */
`timescale 1ns/1ps
module tb_top;
	logic clk_i = 0, rst_i = 1, half = 1, rng = 0, drv_d = 0;
	logic [9:0] base = 10'h3e8, io = 10'h000, r = 10'h041;
	logic busy, tick, mult, drv, rcv, sel, allow;
	int num_errors = 0, checks = 0, hold = 0, q[$];
	line_dir_ctrl #(.HOLD_TICKS(4)) dut (.clk_i(clk_i), .rst_i(rst_i), .tx_busy_i(busy),
		.baud_tick_i(tick), .half_duplex_sel_i(half), .baud_range_high_i(rng),
		.base_addr_i(base), .io_addr_i(io), .ref_clk_mult_o(mult), .driver_en_o(drv),
		.receiver_en_o(rcv), .block_sel_o(sel), .tx_allow_o(allow));
	uart_tx_model u_uart (.clk_i(clk_i), .tx_allow_i(allow), .tx_busy_o(busy),
		.baud_tick_o(tick));
	initial forever #25 clk_i = ~clk_i;
	function logic [9:0] lfsr(input logic [9:0] s);
		return {s[8:0], s[9] ^ s[6]};
	endfunction
	task chk(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t got %b", $time, got);
		end
	endtask
	task final_report;
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task wait_q;
		for (int i = 0; i < 300 && q.size() > 0; i++) step(1);
		if (q.size() > 0) begin
			num_errors++;
			final_report;
		end
	endtask
	// Sampled mid-cycle so the count never races the design's own edge.
	always @(negedge clk_i) begin
		if (busy) hold = 0;
		else if (tick && drv) hold++;
		if (drv_d && !drv && q.size() > 0) chk(hold == q.pop_front(), 1);
		drv_d = drv;
	end
	initial begin
		step(8);
		rst_i = 0;
		step(3);
		for (int i = 0; i < 3; i++) begin
			r = lfsr(r);
			q.push_back(4);
			u_uart.send(1 + r[1:0]);
			wait_q;
		end
		q.push_back(4);
		u_uart.send(1);
		step(19);
		u_uart.send(1);
		wait_q;
		for (int i = 0; i < 6; i++) begin
			r = lfsr(r);
			io = i[0] ? r : {base[9:3], r[2:0]};
			step(2);
			chk(sel, io[9:3] == base[9:3]);
		end
		r = lfsr(r);
		rng = r[0] | 1'b1;
		step(4);
		chk(mult, 1);
		rng = 0;
		step(4);
		chk(mult, 0);
		half = 0;
		u_uart.send(1);
		step(8);
		chk(drv & rcv, 1);
		half = 1;
		step(20);
		base = 10'h100;
		io = 10'h105;
		step(6);
		chk(sel, 1);
		// A reset in mid-run must bring back receive and the default base.
		rst_i = 1;
		step(2);
		rst_i = 0;
		step(1);
		chk(rcv, 1);
		chk(drv, 0);
		chk(sel, 0);
		final_report;
	end
endmodule
